// [logic/ebpi_params.svh]
/*
  Constants of the external bus pin interface: widths, select count, DRAM select, master id codes.
  Assumes it is included once per compilation unit by its bare name.
*/
// Summary of operation
// (R1) Drive 25-bit byte address; float it while bus is released.
// (R2) 16-bit areas use low sixteen lanes; 8-bit areas use lowest eight.
// (R3) Byte access to 32-bit area uses lane chosen by low address bits.
// (R4) Basic spaces pulse cycle start for one cycle with first address.
// (R5) Space 3 select stays off for DRAM; all selects float when released.
// (R6) Direction output shows read or write; serves DRAM write enable.
// (R7) Read strobe low during reads; external buffers drive only then.
// (R8) Shared strobe is output enable for EDO, column strobe for SDRAM.
// (R9) External master requests bus; grant answers; bus floats while released.
// (R10) SDRAM clock enable controlled to enter and hold self-refresh.
// (R11) Refresh due is signalled while released; master should return bus.
// (R12) Four lane strobes map per lane: SDRAM mask, ordinary write enables.
// (R13) DRAM gets four column strobes, one per byte lane.
// (R14) Master id: 00 processor, 01 dma, 10 ethernet dma, 11 other.
// (R15) Force-float with wait floats bus without completing cycle.
// (R16) Vector fetch marks vector cycles and stays driven when released.
// (R17) Wait extends the cycle; wait is ignored while released.
`ifndef EBPI_PARAMS_SVH
`define EBPI_PARAMS_SVH
`define EBPI_ADDR_W 25
`define EBPI_DATA_W 32
`define EBPI_NUM_CS 5
`define EBPI_DRAM_CS 3
`define EBPI_ID_CPU 2'h0
`define EBPI_ID_DMA 2'h1
`define EBPI_ID_EDMA 2'h2
`define EBPI_ID_OTHER 2'h3
`endif

// [logic/ebpi_pkg.sv]
/*
  Types of the external bus pin interface.
  Assumes ebpi_params.svh is available on the include path.
*/
`include "ebpi_params.svh"
package ebpi_pkg;
  typedef enum logic [1:0] {
    EBPI_MEM_NORMAL = 2'h0,
    EBPI_MEM_DRAM = 2'h1,
    EBPI_MEM_EDO = 2'h2,
    EBPI_MEM_SDRAM = 2'h3
  } ebpi_mem_t;
  typedef enum logic [1:0] {
    EBPI_WID_8 = 2'h0,
    EBPI_WID_16 = 2'h1,
    EBPI_WID_32 = 2'h2
  } ebpi_width_t;
  typedef enum logic [1:0] {
    EBPI_MST_CPU = 2'h0,
    EBPI_MST_DMA = 2'h1,
    EBPI_MST_EDMA = 2'h2,
    EBPI_MST_OTHER = 2'h3
  } ebpi_master_t;
  typedef enum logic [1:0] {
    EBPI_ST_IDLE = 2'h0,
    EBPI_ST_ACCESS = 2'h1,
    EBPI_ST_RELEASED = 2'h2
  } ebpi_state_t;
  typedef struct packed {
    logic [`EBPI_ADDR_W-1:0] addr;
    logic [`EBPI_DATA_W-1:0] wdata;
    logic write;
    logic [1:0] size;
    logic [2:0] space;
    ebpi_mem_t mem;
    ebpi_width_t width;
    ebpi_master_t master;
    logic vector;
  } ebpi_req_t;
endpackage

// [logic/ebpi_bus.sv]
/*
  External bus pin interface: drives address, data lanes and strobes for one
  access per request, arbitrates release to an external master.
  Assumes a single 10 MHz clock, an internal requester on the same clock and
  pins resolved outside from the output enables.
*/
`include "ebpi_params.svh"
module ebpi_bus (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input ebpi_pkg::ebpi_req_t i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [`EBPI_DATA_W-1:0] o_rsp_data,
  input wire logic i_refresh_due,
  input wire logic i_self_refresh,
  input wire logic [`EBPI_DATA_W-1:0] i_data_in,
  output logic [`EBPI_DATA_W-1:0] o_data_out,
  output logic o_data_oe,
  output logic [`EBPI_ADDR_W-1:0] o_addr_out,
  output logic [`EBPI_NUM_CS-1:0] o_space_select_n,
  output logic o_cycle_start_n,
  output logic o_rd_wr_n,
  output logic o_read_n,
  output logic o_cas_oe_n,
  output logic o_lane3_strobe_n,
  output logic o_lane2_strobe_n,
  output logic o_lane1_strobe_n,
  output logic o_lane0_strobe_n,
  output logic o_col_lane3_n,
  output logic o_col_lane2_n,
  output logic o_col_lane1_n,
  output logic o_col_lane0_n,
  output logic o_bus_oe,
  input wire logic i_wait_n,
  input wire logic i_force_float_n,
  input wire logic i_release_request_n,
  output logic o_grant_out_n,
  output logic o_sdram_cke,
  output logic o_vector_fetch_n,
  output logic o_refresh_due_n,
  output logic [1:0] o_master_id
);
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic rel_s1_reg;
  logic rel_s2_reg;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1_reg <= 2'h3;
      pin_s2_reg <= 2'h3;
      rel_s1_reg <= 1'b1;
      rel_s2_reg <= 1'b1;
    end else if (i_ce) begin
      pin_s1_reg <= {i_wait_n, i_force_float_n};
      pin_s2_reg <= pin_s1_reg;
      rel_s1_reg <= i_release_request_n;
      rel_s2_reg <= rel_s1_reg;
    end
  end
  wire wait_act = !pin_s2_reg[1];
  wire float_act = !pin_s2_reg[0] && wait_act;
  wire rel_req = !rel_s2_reg;

  ebpi_pkg::ebpi_state_t state_reg;
  ebpi_pkg::ebpi_state_t state_next;
  ebpi_pkg::ebpi_req_t cur_reg;
  logic first_reg;
  logic [`EBPI_DATA_W-1:0] rdata_reg;
  logic rsp_reg;
  logic cke_reg;

  wire in_access = state_reg == ebpi_pkg::EBPI_ST_ACCESS;
  wire released = state_reg == ebpi_pkg::EBPI_ST_RELEASED;
  wire take = state_reg == ebpi_pkg::EBPI_ST_IDLE && i_req_valid && !rel_req;
  // Wait is only seen while the device owns the bus, never during release.
  wire stretch = in_access && wait_act; // [R17]
  wire finish = in_access && !wait_act;
  wire is_dram = cur_reg.mem == ebpi_pkg::EBPI_MEM_DRAM ||
                 cur_reg.mem == ebpi_pkg::EBPI_MEM_EDO;
  wire is_sdram = cur_reg.mem == ebpi_pkg::EBPI_MEM_SDRAM;
  wire is_basic = cur_reg.mem == ebpi_pkg::EBPI_MEM_NORMAL;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ebpi_pkg::EBPI_ST_IDLE: begin
        if (rel_req) begin
          state_next = ebpi_pkg::EBPI_ST_RELEASED; // [R9]
        end else if (i_req_valid) begin
          state_next = ebpi_pkg::EBPI_ST_ACCESS;
        end
      end
      ebpi_pkg::EBPI_ST_ACCESS: begin
        if (finish) begin
          state_next = ebpi_pkg::EBPI_ST_IDLE;
        end
      end
      ebpi_pkg::EBPI_ST_RELEASED: begin
        if (!rel_req) begin
          state_next = ebpi_pkg::EBPI_ST_IDLE;
        end
      end
      default: state_next = ebpi_pkg::EBPI_ST_IDLE;
    endcase
  end

  // Byte lane mask from size, width and low address bits.
  logic [3:0] lanes;
  always_comb begin
    lanes = 4'hF;
    case (cur_reg.width)
      ebpi_pkg::EBPI_WID_8: lanes = 4'h1; // [R2]
      ebpi_pkg::EBPI_WID_16: lanes = (cur_reg.size == 2'h0) ?
        (cur_reg.addr[0] ? 4'h1 : 4'h2) : 4'h3; // [R2]
      ebpi_pkg::EBPI_WID_32: begin
        if (cur_reg.size == 2'h0) begin
          lanes = 4'h8 >> cur_reg.addr[1:0]; // [R3]
        end else if (cur_reg.size == 2'h1) begin
          lanes = cur_reg.addr[1] ? 4'h3 : 4'hC;
        end
      end
      default: lanes = 4'hF;
    endcase
  end

  // A byte goes out on every lane so that each width finds it on its own lane.
  wire [`EBPI_DATA_W-1:0] lane_data = (cur_reg.size == 2'h0) ?
    {4{cur_reg.wdata[7:0]}} : cur_reg.wdata; // [R2] [R3]
  wire [7:0] byte_16 = cur_reg.addr[0] ? i_data_in[7:0] : i_data_in[15:8]; // [R2]
  wire [7:0] byte_sel = cur_reg.width == ebpi_pkg::EBPI_WID_32 ?
    i_data_in[8*(3-cur_reg.addr[1:0]) +: 8] :
    (cur_reg.width == ebpi_pkg::EBPI_WID_16 ? byte_16 : i_data_in[7:0]); // [R3]
  wire [`EBPI_DATA_W-1:0] cap_data = (cur_reg.size == 2'h0) ? {24'h000000, byte_sel} :
    (cur_reg.width == ebpi_pkg::EBPI_WID_32 && cur_reg.size == 2'h1) ?
    {16'h0000, cur_reg.addr[1] ? i_data_in[15:0] : i_data_in[31:16]} : i_data_in;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ebpi_pkg::EBPI_ST_IDLE;
      cur_reg <= '0;
      first_reg <= 1'b0;
      rdata_reg <= '0;
      rsp_reg <= 1'b0;
      cke_reg <= 1'b1;
    end else if (i_ce) begin
      state_reg <= state_next;
      first_reg <= take;
      rsp_reg <= finish;
      if (take) begin
        cur_reg <= i_req;
      end
      if (finish && !cur_reg.write) begin
        rdata_reg <= cap_data;
      end
      cke_reg <= !i_self_refresh; // [R10]
    end
  end

  // A forced float drops the drivers mid-cycle; the cycle is stretched, not ended.
  wire drive = !released && !float_act; // [R1] [R9] [R15]
  wire act = in_access && !float_act;
  wire rd = act && !cur_reg.write;
  wire wr = act && cur_reg.write;
  logic [`EBPI_NUM_CS-1:0] cs_on;
  always_comb begin
    cs_on = '0;
    cs_on[cur_reg.space] = act;
    if (cur_reg.space == 3'(`EBPI_DRAM_CS) && is_dram) begin
      cs_on[cur_reg.space] = 1'b0; // [R5]
    end
  end

  assign o_req_ready = state_reg == ebpi_pkg::EBPI_ST_IDLE && !rel_req;
  assign o_rsp_valid = rsp_reg;
  assign o_rsp_data = rdata_reg;
  assign o_bus_oe = drive; // [R1] [R5] [R9]
  assign o_addr_out = cur_reg.addr; // [R1]
  assign o_data_out = lane_data;
  assign o_data_oe = wr && drive; // [R7]
  assign o_space_select_n = ~cs_on; // [R5]
  assign o_cycle_start_n = !(act && first_reg && is_basic); // [R4]
  assign o_rd_wr_n = !wr; // [R6]
  assign o_read_n = !rd; // [R7]
  assign o_cas_oe_n = !((cur_reg.mem == ebpi_pkg::EBPI_MEM_EDO && rd) ||
    (is_sdram && act)); // [R8]
  // For SDRAM the pin is a mask: low on the lanes in use, high on the rest.
  assign o_lane3_strobe_n = !(act && (is_sdram ? lanes[3] : cur_reg.write && lanes[3])); // [R12]
  assign o_lane2_strobe_n = !(act && (is_sdram ? lanes[2] : cur_reg.write && lanes[2])); // [R12]
  assign o_lane1_strobe_n = !(act && (is_sdram ? lanes[1] : cur_reg.write && lanes[1])); // [R12]
  assign o_lane0_strobe_n = !(act && (is_sdram ? lanes[0] : cur_reg.write && lanes[0])); // [R12]
  assign o_col_lane3_n = !(act && is_dram && lanes[3]); // [R13]
  assign o_col_lane2_n = !(act && is_dram && lanes[2]); // [R13]
  assign o_col_lane1_n = !(act && is_dram && lanes[1]); // [R13]
  assign o_col_lane0_n = !(act && is_dram && lanes[0]); // [R13]
  assign o_grant_out_n = !released; // [R9]
  assign o_sdram_cke = cke_reg; // [R10]
  assign o_vector_fetch_n = !(in_access && cur_reg.vector); // [R16]
  assign o_refresh_due_n = !(released && i_refresh_due); // [R11]
  assign o_master_id = cur_reg.master; // [R14]
endmodule

// [tb/ebpi_bus_sva.sv]
/* Port checker of the bus pin interface. Assumes one clock, active-low reset, a bind. */
module ebpi_bus_sva (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_req_valid,
  input ebpi_pkg::ebpi_req_t i_req,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic i_wait_n,
  input wire logic [4:0] o_space_select_n,
  input wire logic o_cycle_start_n,
  input wire logic o_bus_oe,
  input wire logic o_grant_out_n,
  input wire logic o_refresh_due_n,
  input wire logic [1:0] o_master_id
);
  timeunit 1ns / 1ns;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  wire take = i_req_valid && o_req_ready;
  wire basic = i_req.mem == ebpi_pkg::EBPI_MEM_NORMAL;
  wire dram = i_req.mem == ebpi_pkg::EBPI_MEM_DRAM;
  AST_START_ONE: assert property ($fell(o_cycle_start_n) |=> o_cycle_start_n)
    else $error("cycle start held past one cycle");
  AST_START_TAKE: assert property (take |=> o_cycle_start_n == !$past(basic))
    else $error("cycle start wrong for space kind");
  AST_CS3_DRAM: assert property (take && dram |=> o_space_select_n[3])
    else $error("space 3 selected for dram");
  AST_RSP_TIME: assert property (
    take && i_wait_n && $past(i_wait_n) && $past(i_wait_n, 2) |-> ##2 o_rsp_valid)
    else $error("response late without wait");
  AST_MASTER_ID: assert property (take |=> o_master_id == $past(i_req.master))
    else $error("master id wrong");
  AST_RELEASE_FLOAT: assert property (!o_grant_out_n |-> !o_bus_oe)
    else $error("bus driven while released");
  AST_REFRESH_RELEASED: assert property (!o_refresh_due_n |-> !o_grant_out_n)
    else $error("refresh request outside release");
  AST_RELEASE_REFUSE: assert property (!o_grant_out_n |-> !o_req_ready)
    else $error("request accepted while released");
endmodule

// [tb/ebpi_mem_model.sv]
/* Far-side memory answering reads with one word. Assumes it alone drives the data input. */
module ebpi_mem_model (
  input wire logic i_clock,
  input wire logic i_read_n,
  input wire logic i_bus_oe,
  output logic [31:0] o_data
);
  timeunit 1ns / 1ns;
  logic [31:0] last_reg = 32'h0;
  // Off the read strobe the lines flip each cycle, so a stale sample cannot pass.
  assign o_data = (!i_read_n && i_bus_oe) ? 32'h11223344 : ~last_reg;
  always_ff @(posedge i_clock) last_reg <= o_data;
endmodule

// [tb/ebpi_bus_bench.sv]
/* Bench of the bus pin interface. Assumes the package, memory model and checker. */
module ebpi_bus_bench;
  timeunit 1ns / 1ns;
  logic i_clock = 1'h0, i_nrst = 1'h0, i_ce = 1'h1, i_req_valid = 1'h0, i_refresh_due = 1'h0;
  logic i_self_refresh = 1'h0, i_wait_n = 1'h1, i_force_float_n = 1'h1;
  logic i_release_request_n = 1'h1;
  ebpi_pkg::ebpi_req_t i_req = 70'h0;
  logic [31:0] i_data_in, o_rsp_data, o_data_out;
  logic [24:0] o_addr_out;
  logic [11:0] obs;
  logic [4:0] o_space_select_n;
  logic [1:0] o_master_id;
  logic o_req_ready, o_rsp_valid, o_data_oe, o_cycle_start_n, o_rd_wr_n, o_read_n, o_cas_oe_n;
  logic o_lane3_strobe_n, o_lane2_strobe_n, o_lane1_strobe_n, o_lane0_strobe_n, o_bus_oe;
  logic o_col_lane3_n, o_col_lane2_n, o_col_lane1_n, o_col_lane0_n, o_grant_out_n;
  logic o_sdram_cke, o_vector_fetch_n, o_refresh_due_n;
  int err_total = 0, compares = 0, n;
  ebpi_bus dut (.*);
  ebpi_mem_model far_mem (.i_clock, .i_read_n(o_read_n), .i_bus_oe(o_bus_oe), .o_data(i_data_in));
  always #50 i_clock = ~i_clock;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_for(ref logic s, input logic lv);
    for (n = 0; n < 50 && s !== lv; n++) @(posedge i_clock) #10;
  endtask
  // The code c packs write, memory kind, width, master and vector fetch, top bit first.
  task automatic xfer(input logic [24:0] a, input logic [7:0] c, input logic [19:0] e, m);
    i_req = {a, 32'h000000A6, c[7], 5'h03, c[6:0]};
    wait_for(o_req_ready, 1'h1);
    i_req_valid = 1'h1;
    @(posedge i_clock) #10;
    i_req_valid = 1'h0;
    obs = {o_space_select_n[3], o_master_id, o_vector_fetch_n, o_lane3_strobe_n, o_lane2_strobe_n,
      o_lane1_strobe_n, o_lane0_strobe_n, o_col_lane3_n, o_col_lane2_n, o_col_lane1_n, o_col_lane0_n};
    cmp("addr", 32'(a), 32'(o_addr_out));
    cmp("ctl", 32'({!c[7], c[7], c[7], c[6:5] != 2'h0,
      !((c[6:5] == 2'h2 && !c[7]) || c[6:5] == 2'h3)}),
      32'({o_rd_wr_n, o_read_n, o_data_oe, o_cycle_start_n, o_cas_oe_n}));
    if (c[7]) cmp("wdata", 32'hA6A6A6A6, o_data_out);
    wait_for(o_rsp_valid, 1'h1);
    cmp("lanes", 32'(e), 32'({o_rsp_data[7:0], obs} & m));
  endtask
  task automatic t_lanes;
    xfer(25'h0, 8'h10, 20'h11000, 20'hFF000);
    xfer(25'h3, 8'h10, 20'h44000, 20'hFF000);
    xfer(25'h0, 8'h08, 20'h33000, 20'hFF000);
    xfer(25'h0, 8'h00, 20'h44000, 20'hFF000);
    xfer(25'h1, 8'h92, 20'h002B0, 20'h006F0);
    xfer(25'h0, 8'hF5, 20'h00470, 20'h007F0);
    xfer(25'h0, 8'h36, 20'h00E07, 20'h00E0F);
  endtask
  task automatic t_wait;
    i_wait_n = 1'h0;
    repeat (3) @(posedge i_clock) #10;
    i_req = {25'h0, 32'h000000A6, 1'h0, 5'h03, 7'h40};
    i_req_valid = 1'h1;
    @(posedge i_clock) #10;
    i_req_valid = 1'h0;
    repeat (4) @(posedge i_clock) #10;
    cmp("stretched", 32'h0, 32'({o_rsp_valid, o_read_n, o_cas_oe_n}));
    i_force_float_n = 1'h0;
    repeat (3) @(posedge i_clock) #10;
    cmp("floated", 32'h0, 32'({o_bus_oe, o_rsp_valid}));
    {i_wait_n, i_force_float_n} = 2'h3;
    wait_for(o_rsp_valid, 1'h1);
    cmp("resumed", 32'h144, 32'({o_rsp_valid, o_rsp_data[7:0]}));
  endtask
  task automatic t_release;
    {i_refresh_due, i_release_request_n} = 2'h2;
    wait_for(o_grant_out_n, 1'h0);
    i_self_refresh = 1'h1;
    repeat (3) @(posedge i_clock) #10;
    cmp("released", 32'h0, 32'({o_bus_oe, o_refresh_due_n, o_sdram_cke}));
    {i_refresh_due, i_release_request_n, i_self_refresh} = 3'h2;
    wait_for(o_grant_out_n, 1'h1);
    cmp("grant_n", 32'h1, 32'(o_grant_out_n));
  endtask
  task automatic end_sim;
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clock) #10;
    i_nrst = 1'h1;
    t_lanes();
    t_wait();
    t_release();
    t_lanes();
    end_sim();
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
bind ebpi_bus ebpi_bus_sva chk (.*);
